// ---- tb/sea_enc_model.sv ----
// encoder stand-in: alert levels, battery level and turn pulses
`timescale 1ns/10ps
`default_nettype none
module sea_enc_model
  import sea_pkg::*;
(
  input  wire logic               mclk,
  output logic [ALERT_EVENTS-1:0] enc_events,
  output logic [15:0]             batt_mv,
  output logic                    turn_up,
  output logic                    turn_down
);
  // battery starts healthy, above the warning band
  initial begin
    enc_events = '0;
    batt_mv    = 16'h0ce4;
    turn_up    = 1'b0;
    turn_down  = 1'b0;
  end
  task automatic set_alerts(input logic [ALERT_EVENTS-1:0] v);
    @(posedge mclk);
    enc_events <= v;
  endtask : set_alerts
  task automatic set_batt(input logic [15:0] mv);
    @(posedge mclk);
    batt_mv <= mv;
  endtask : set_batt
  // one turn per pulse; dropped again so a level never counts twice
  task automatic step(input logic up);
    @(posedge mclk);
    turn_up   <= up;
    turn_down <= !up;
    @(posedge mclk);
    turn_up   <= 1'b0;
    turn_down <= 1'b0;
  endtask : step
endmodule : sea_enc_model
`default_nettype wire

// ---- tb/tb_sea_regs.sv ----
// testbench for the alert word and tuning bank
`timescale 1ns/10ps
`default_nettype none
module tb_sea_regs
  import sea_pkg::*;
;
  logic mclk = 1'b0, rst = 1'b1, mconn = 1'b0, ptm = 1'b0, egf = 1'b0;
  logic pm = 1'b0;
  logic [15:0] kopt = 16'h0000;
  sea_req_t req = '0;
  logic [31:0] rdata, gd;
  logic rvalid, t_up, t_dn, mtc, ues, gfa;
  logic [ALERT_EVENTS-1:0] ev;
  logic [15:0] mv, tc, keff;
  sea_tune_t tune;
  int errors = 0, cmp_count = 0;
  logic [31:0] exp_q[$];
  logic [11:0] ta[15];
  logic [31:0] td[15], te[15];
  logic [31:0] r;
  always #5 mclk = ~mclk;
  sea_enc_model sea_enc_model_i (.mclk(mclk), .enc_events(ev),
    .batt_mv(mv), .turn_up(t_up), .turn_down(t_dn));
  sea_regs sea_regs_i (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata),
    .rvalid(rvalid), .enc_events(ev), .batt_mv(mv), .turn_up(t_up),
    .turn_down(t_dn), .motor_connect(mconn), .pgain_optimised(kopt),
    .pulse_train_mode(ptm), .enhanced_gear_filter(egf),
    .position_mode(pm), .turn_count(tc), .mt_count_clear(mtc),
    .use_encoder_speed(ues), .gear_depth_eff(gd),
    .gear_filter_active(gfa), .pgain_eff(keff), .tune(tune));
  task automatic wrap_up;
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req <= '0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    exp_q.push_back(e);
    @(posedge mclk);
    req <= '0;
  endtask : rd
  // read answers are matched in request order, sampled mid-cycle
  always @(negedge mclk) begin
    if (rvalid === 1'b1)
      chk("rdata", rdata, exp_q.size() ? exp_q.pop_front() : 32'hdead_beef);
  end
  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    wrap_up();
  end
  initial begin
    ta = '{OFS_GEAR, OFS_GEAR, OFS_GEAR, OFS_GEAR,
      OFS_PGAIN, OFS_PGAIN, OFS_PGAIN,
      OFS_KPVFF, OFS_KPVFF, OFS_KPVFF, OFS_KPVFF, OFS_SPDSRC, OFS_SPDSRC,
      OFS_SPDSRC, OFS_ALERT};
    td = '{32'h4a, 32'h4b, 32'hc81, 32'hc80, 32'h2ee1, 32'h2ee0, 32'h1_0005,
      32'hffff_f82f, KPV_MIN, 32'h7d1, 32'h7d0, 32'h1, 32'h3, 32'h2,
      32'hffff_ffff};
    te = '{GEAR_RST, 32'h4b, 32'h4b, 32'hc80, 32'h12c, 32'h2ee0, 32'h2ee0,
      KPV_RST, KPV_MIN, KPV_MIN, 32'h7d0, 32'h0, 32'h3, 32'h3, 32'h0};
    void'($urandom(70507));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(OFS_GEAR, GEAR_RST);
    rd(OFS_PGAIN, {16'h0, PGAIN_RST});
    rd(OFS_KPVFF, KPV_RST);
    rd(OFS_SPDSRC, 32'h0);
    rd(12'h964, 32'h0);
    for (int i = 0; i < 15; i++) begin
      wr(ta[i], td[i]);
      rd(ta[i], te[i]);
    end
    ptm <= 1'b1;
    egf <= 1'b1;
    pm  <= 1'b1;
    @(negedge mclk);
    chk("use_encoder_speed", {31'h0, ues}, 32'h1);
    chk("gear_depth_eff", gd, 32'hc80);
    chk("gear_filter_active", {31'h0, gfa}, 32'h1);
    chk("pgain_eff", {16'h0, keff}, 32'h2ee0);
    @(posedge mclk);
    egf <= 1'b0;
    pm  <= 1'b0;
    @(negedge mclk);
    chk("gear_depth_eff", gd, 32'h0);
    chk("pgain_eff", {16'h0, keff}, 32'h0);
    r = $urandom % 12001;
    wr(OFS_PGAIN, r);
    rd(OFS_PGAIN, r);
    for (int i = 0; i < ALERT_EVENTS; i++) begin
      sea_enc_model_i.set_alerts(10'h1 << i);
      rd(OFS_ALERT, 32'h1 << i);
    end
    // bit 6 must be up for the factory values to show
    sea_enc_model_i.set_alerts(10'h1 << BIT_PARAM_BAD);
    @(posedge mclk);
    @(negedge mclk);
    chk("tune.gear_depth", tune.gear_depth, GEAR_RST);
    chk("tune.pgain", {16'h0, tune.pgain}, {16'h0, PGAIN_RST});
    chk("tune.kpvff", tune.kpvff, KPV_RST);
    sea_enc_model_i.set_alerts('0);
    rd(OFS_PGAIN, r);
    for (int k = 0; k < 4; k++) begin
      sea_enc_model_i.set_batt(k[0] ^ k[1] ? BATT_LO_MV + 16'(k / 2 * 150)
        : BATT_LO_MV - 16'h1 + 16'(k / 2 * 152));
      rd(OFS_ALERT, (k == 1 || k == 2) ? 32'h400 : 32'h0);
    end
    sea_enc_model_i.step(1'b0);
    repeat (2) @(posedge mclk);
    rd(OFS_ALERT, 32'h1000);
    chk("turn_count", {16'h0, tc}, 32'hffff);
    sea_enc_model_i.step(1'b1);
    sea_enc_model_i.step(1'b1);
    @(negedge mclk);
    chk("turn_count", {16'h0, tc}, 32'h1);
    wr(OFS_MTCMD, 32'h2);
    @(negedge mclk);
    chk("mt_count_clear", {31'h0, mtc}, 32'h1);
    chk("turn_count", {16'h0, tc}, 32'h0);
    rd(OFS_ALERT, 32'h0);
    kopt  <= 16'h0309;
    mconn <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(OFS_PGAIN, 32'h309);
    repeat (3) @(posedge mclk);
    if (exp_q.size() != 0) errors++;
    wrap_up();
  end
endmodule : tb_sea_regs
`default_nettype wire

// ---- verilog/sea_pkg.sv ----
// package: offsets, field layout, limits and carriers for the tuning bank
package sea_pkg;
  localparam logic [11:0] OFS_ALERT  = 12'h962;
  localparam logic [11:0] OFS_SPDSRC = 12'h966;
  localparam logic [11:0] OFS_GEAR   = 12'h968;
  localparam logic [11:0] OFS_PGAIN  = 12'h96a;
  localparam logic [11:0] OFS_KPVFF  = 12'h96c;
  localparam logic [11:0] OFS_MTCMD  = 12'h958;

  localparam int BIT_OVER_TEMP  = 0;
  localparam int BIT_UNDER_TEMP = 1;
  localparam int BIT_OVER_SPEED = 2;
  localparam int BIT_OVER_ACCEL = 3;
  localparam int BIT_NV_CSUM    = 4;
  localparam int BIT_NV_EMPTY   = 5;
  localparam int BIT_PARAM_BAD  = 6;
  localparam int BIT_DECODE_SEQ = 7;
  localparam int BIT_FLASH_ERR  = 8;
  localparam int BIT_SHAFT_DISP = 9;
  localparam int BIT_BATT_LOW   = 10;
  localparam int BIT_MT_RANGE   = 12;
  localparam int ALERT_EVENTS   = 10;

  localparam logic [15:0] BATT_LO_MV = 16'h0bb8;
  localparam logic [15:0] BATT_HI_MV = 16'h0c4e;

  localparam logic [15:0] SPD_DRIVE   = 16'h0000;
  localparam logic [15:0] SPD_ENCODER = 16'h0003;

  localparam logic [31:0] GEAR_MIN = 32'h0000_004b;
  localparam logic [31:0] GEAR_MAX = 32'h0000_0c80;
  localparam logic [31:0] GEAR_RST = 32'h0000_00c8;
  localparam logic [15:0] PGAIN_MAX = 16'h2ee0;
  localparam logic [15:0] PGAIN_RST = 16'h012c;
  localparam logic [31:0] KPV_MIN  = 32'hffff_f830;
  localparam logic [31:0] KPV_MAX  = 32'h0000_07d0;
  localparam logic [31:0] KPV_RST  = 32'h0000_01f4;
  localparam logic [15:0] MT_RESET_CMD = 16'h0002;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } sea_req_t;

  typedef struct packed {
    logic [31:0] gear_depth;
    logic [15:0] pgain;
    logic [31:0] kpvff;
  } sea_tune_t;
endpackage : sea_pkg

// ---- verilog/sea_range_chk.sv ----
// range checker: accepts a write value only inside signed or unsigned bounds
`timescale 1ns/10ps
`default_nettype none
module sea_range_chk #(
  parameter int W = 32,
  parameter bit SIGNED = 1'b0
) (
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] lo,
  input  wire logic [W-1:0] hi,
  output logic              in_range
);
  wire ge_s = $signed(value) >= $signed(lo);
  wire le_s = $signed(value) <= $signed(hi);
  wire ge_u = value >= lo;
  wire le_u = value <= hi;
  assign in_range = SIGNED ? (ge_s && le_s) : (ge_u && le_u);
endmodule : sea_range_chk
`default_nettype wire

// ---- verilog/sea_regs.sv ----
// encoder alert word, speed source selector and position loop tuning bank
//
// How it works
// - encoder over-temperature sets alert bit 0, under-temperature bit 1.
// - encoder over-speed sets bit 2, over-acceleration sets bit 3.
// - nonvolatile checksum mismatch at initialisation sets bit 4.
// - empty nonvolatile storage sets bit 5.
// - invalid parameter area sets bit 6; defaults then used.
// - invalid position decoding sequence sets bit 7.
// - encoder flash error sets bit 8.
// - unusual large shaft displacement sets bit 9.
// - bit 10 set while battery is within 3000..3150 mV.
// - bit 12 latches on turn count overflow, cleared by command 2.
// - multi-turn count is unsigned 0..65535.
// - speed source accepts 0 (drive computed) or 3 (encoder).
// - gear depth 75..3200, default 200, used only with enhanced gear filter in pulse-train mode.
// - position gain 0..12000 unsigned, default 300, position modes.
// - motor connection loads optimised position gain.
// - feedforward signed -2000..2000, default 500.
// - multi-turn command value 2 resets revolution count to zero.
`timescale 1ns/10ps
`default_nettype none
module sea_regs
  import sea_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire sea_req_t                req,
  output logic [31:0]                  rdata,
  output logic                         rvalid,
  input  wire logic [ALERT_EVENTS-1:0] enc_events,
  input  wire logic [15:0]             batt_mv,
  input  wire logic                    turn_up,
  input  wire logic                    turn_down,
  input  wire logic                    motor_connect,
  input  wire logic [15:0]             pgain_optimised,
  input  wire logic                    pulse_train_mode,
  input  wire logic                    enhanced_gear_filter,
  input  wire logic                    position_mode,
  output logic [15:0]                  turn_count,
  output logic                         mt_count_clear,
  output logic                         use_encoder_speed,
  output logic [31:0]                  gear_depth_eff,
  output logic                         gear_filter_active,
  output logic [15:0]                  pgain_eff,
  output sea_tune_t                    tune
);
  logic [ALERT_EVENTS-1:0] evt_seen;
  logic                    mt_over;
  logic [15:0]             spd_src;
  logic [31:0]             gear_depth;
  logic [15:0]             pgain;
  logic [31:0]             kpvff;
  logic                    motor_connect_d;
  logic                    gear_ok;
  logic                    pgain_ok;
  logic                    kpv_ok;

  wire wr_spd   = req.wr && (req.addr == OFS_SPDSRC);
  wire wr_gear  = req.wr && (req.addr == OFS_GEAR);
  wire wr_pgain = req.wr && (req.addr == OFS_PGAIN);
  wire wr_kpv   = req.wr && (req.addr == OFS_KPVFF);
  wire wr_mtcmd = req.wr && (req.addr == OFS_MTCMD);
  wire mt_reset = wr_mtcmd && (req.wdata[15:0] == MT_RESET_CMD);
  wire upper_zero = (req.wdata[31:16] == 16'h0000);
  wire spd_ok   = upper_zero &&
                  ((req.wdata[15:0] == SPD_DRIVE) ||
                   (req.wdata[15:0] == SPD_ENCODER));
  wire batt_low = (batt_mv >= BATT_LO_MV) && (batt_mv <= BATT_HI_MV);
  wire wrap_up   = turn_up && !turn_down && (turn_count == 16'hffff);
  wire wrap_down = turn_down && !turn_up && (turn_count == 16'h0000);
  wire connect_rise = motor_connect && !motor_connect_d;

  sea_range_chk #(.W(32), .SIGNED(1'b0)) u_gear_chk (
    .value    (req.wdata),
    .lo       (GEAR_MIN),
    .hi       (GEAR_MAX),
    .in_range (gear_ok)
  );
  sea_range_chk #(.W(16), .SIGNED(1'b0)) u_pgain_chk (
    .value    (req.wdata[15:0]),
    .lo       (16'h0000),
    .hi       (PGAIN_MAX),
    .in_range (pgain_ok)
  );
  sea_range_chk #(.W(32), .SIGNED(1'b1)) u_kpv_chk (
    .value    (req.wdata),
    .lo       (KPV_MIN),
    .hi       (KPV_MAX),
    .in_range (kpv_ok)
  );

  // alert bits 0..9 follow the encoder's reported conditions
  genvar gi;
  generate
    for (gi = 0; gi < ALERT_EVENTS; gi++) begin : g_evt
      always_ff @(posedge mclk) begin
        if (rst) begin
          evt_seen[gi] <= 1'b0;
        end else begin
          evt_seen[gi] <= enc_events[gi];
        end
      end
    end
  endgenerate

  // count wraps modulo 2^16; overflow latches until command 2
  always_ff @(posedge mclk) begin
    if (rst) begin
      turn_count <= 16'h0000;
    end else if (mt_reset) begin
      turn_count <= 16'h0000;
    end else if (turn_up && !turn_down) begin
      turn_count <= turn_count + 16'h0001;
    end else if (turn_down && !turn_up) begin
      turn_count <= turn_count - 16'h0001;
    end
  end

  // a wrap in the same cycle as the clearing command still sets
  always_ff @(posedge mclk) begin
    if (rst) begin
      mt_over <= 1'b0;
    end else if (wrap_up || wrap_down) begin
      mt_over <= 1'b1;
    end else if (mt_reset) begin
      mt_over <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mt_count_clear <= 1'b0;
    end else begin
      mt_count_clear <= mt_reset;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      spd_src <= SPD_DRIVE;
    end else if (wr_spd && spd_ok) begin
      spd_src <= req.wdata[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      gear_depth <= GEAR_RST;
    end else if (wr_gear && gear_ok) begin
      gear_depth <= req.wdata;
    end
  end

  // motor connection overrides a same-cycle software write of the gain
  always_ff @(posedge mclk) begin
    if (rst) begin
      pgain           <= PGAIN_RST;
      motor_connect_d <= 1'b0;
    end else begin
      motor_connect_d <= motor_connect;
      if (connect_rise && (pgain_optimised <= PGAIN_MAX)) begin
        pgain <= pgain_optimised;
      end else if (wr_pgain && pgain_ok && upper_zero) begin
        pgain <= req.wdata[15:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      kpvff <= KPV_RST;
    end else if (wr_kpv && kpv_ok) begin
      kpvff <= req.wdata;
    end
  end

  wire [31:0] alert_word = {19'h0, mt_over, 1'b0, batt_low, evt_seen};

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata  <= 32'h0000_0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      case (req.addr)
        OFS_ALERT:  rdata <= alert_word;
        OFS_SPDSRC: rdata <= {16'h0000, spd_src};
        OFS_GEAR:   rdata <= gear_depth;
        OFS_PGAIN:  rdata <= {16'h0000, pgain};
        OFS_KPVFF:  rdata <= kpvff;
        default:    rdata <= 32'h0000_0000;
      endcase
    end
  end

  // parameter area invalid: consumers see factory values
  wire use_defaults = evt_seen[BIT_PARAM_BAD];
  assign use_encoder_speed  = !use_defaults &&
                              (spd_src == SPD_ENCODER);
  assign gear_filter_active = pulse_train_mode && enhanced_gear_filter;
  assign gear_depth_eff = gear_filter_active ?
                          (use_defaults ? GEAR_RST : gear_depth) : 32'h0;
  assign pgain_eff = position_mode ?
                     (use_defaults ? PGAIN_RST : pgain) : 16'h0;
  assign tune.gear_depth = use_defaults ? GEAR_RST : gear_depth;
  assign tune.pgain      = use_defaults ? PGAIN_RST : pgain;
  assign tune.kpvff      = use_defaults ? KPV_RST : kpvff;

  a_alert_follow: assert property (
    @(posedge mclk) disable iff (rst)
    enc_events[BIT_OVER_TEMP] |=> evt_seen[BIT_OVER_TEMP])
    else $error("over temperature alert not set");
  a_cold_follow: assert property (
    @(posedge mclk) disable iff (rst)
    enc_events[BIT_UNDER_TEMP] |=> alert_word[BIT_UNDER_TEMP])
    else $error("under temperature alert not set");
  a_alert_live: assert property (
    @(posedge mclk) disable iff (rst)
    !enc_events[BIT_OVER_TEMP] |=> !alert_word[BIT_OVER_TEMP])
    else $error("over temperature alert stuck");
  a_speed_follow: assert property (
    @(posedge mclk) disable iff (rst)
    enc_events[BIT_OVER_SPEED] |=> alert_word[BIT_OVER_SPEED])
    else $error("over speed alert not set");
  a_accel_follow: assert property (
    @(posedge mclk) disable iff (rst)
    enc_events[BIT_OVER_ACCEL] |=> alert_word[BIT_OVER_ACCEL])
    else $error("over acceleration alert not set");
  a_csum_follow: assert property (
    @(posedge mclk) disable iff (rst)
    enc_events[BIT_NV_CSUM] |=> alert_word[BIT_NV_CSUM])
    else $error("checksum alert not set");
  a_empty_follow: assert property (
    @(posedge mclk) disable iff (rst)
    enc_events[BIT_NV_EMPTY] |=> alert_word[BIT_NV_EMPTY])
    else $error("empty storage alert not set");
  a_param_follow: assert property (
    @(posedge mclk) disable iff (rst)
    enc_events[BIT_PARAM_BAD] |=> alert_word[BIT_PARAM_BAD])
    else $error("parameter area alert not set");
  a_defaults_used: assert property (
    @(posedge mclk) disable iff (rst)
    alert_word[BIT_PARAM_BAD] |-> (tune.gear_depth == GEAR_RST) &&
    (tune.pgain == PGAIN_RST) && (tune.kpvff == KPV_RST))
    else $error("defaults not used with bad parameter area");
  a_decode_follow: assert property (
    @(posedge mclk) disable iff (rst)
    enc_events[BIT_DECODE_SEQ] |=> alert_word[BIT_DECODE_SEQ])
    else $error("decode sequence alert not set");
  a_flash_bit: assert property (
    @(posedge mclk) disable iff (rst)
    $rose(enc_events[BIT_FLASH_ERR]) |=> alert_word[BIT_FLASH_ERR])
    else $error("flash alert not set");
  a_disp_follow: assert property (
    @(posedge mclk) disable iff (rst)
    enc_events[BIT_SHAFT_DISP] |=> alert_word[BIT_SHAFT_DISP])
    else $error("shaft displacement alert not set");
  a_batt_band: assert property (
    @(posedge mclk) disable iff (rst)
    alert_word[BIT_BATT_LOW] ==
    ((batt_mv >= 16'd3000) && (batt_mv <= 16'd3150)))
    else $error("battery band alert wrong");
  a_mt_latch: assert property (
    @(posedge mclk) disable iff (rst)
    (mt_over && !mt_reset) |=> mt_over)
    else $error("overflow alert dropped without command");
  a_mt_wrap: assert property (
    @(posedge mclk) disable iff (rst)
    wrap_up |=> mt_over && (turn_count == 16'h0000))
    else $error("wrap did not latch overflow");
  a_mt_wrap_down: assert property (
    @(posedge mclk) disable iff (rst)
    wrap_down |=> mt_over && (turn_count == 16'hffff))
    else $error("downward wrap did not latch overflow");
  a_reserved_zero: assert property (
    @(posedge mclk) disable iff (rst)
    !alert_word[BIT_MT_RANGE-1] && (alert_word[31:BIT_MT_RANGE+1] == '0))
    else $error("reserved alert bits set");
  a_turn_step: assert property (
    @(posedge mclk) disable iff (rst)
    (turn_up && !turn_down && !mt_reset) |=>
    turn_count == $past(turn_count) + 16'h0001)
    else $error("revolution count did not step");
  a_spd_legal: assert property (
    @(posedge mclk) disable iff (rst)
    (spd_src == 16'd0) || (spd_src == 16'd3))
    else $error("speed source illegal");
  a_spd_source: assert property (
    @(posedge mclk) disable iff (rst)
    use_encoder_speed |-> (spd_src == SPD_ENCODER))
    else $error("encoder speed used without selection");
  a_gear_range: assert property (
    @(posedge mclk) disable iff (rst)
    (gear_depth >= GEAR_MIN) && (gear_depth <= GEAR_MAX))
    else $error("gear depth out of range");
  a_gear_load: assert property (
    @(posedge mclk) disable iff (rst)
    (wr_gear && gear_ok) |=> gear_depth == $past(req.wdata))
    else $error("legal gear write not taken");
  a_gear_idle: assert property (
    @(posedge mclk) disable iff (rst)
    !gear_filter_active |-> (gear_depth_eff == 32'h0))
    else $error("gear depth applied outside gear mode");
  a_pgain_range: assert property (
    @(posedge mclk) disable iff (rst)
    pgain <= 16'd12000)
    else $error("position gain out of range");
  a_pgain_idle: assert property (
    @(posedge mclk) disable iff (rst)
    !position_mode |-> (pgain_eff == 16'h0))
    else $error("position gain applied outside position modes");
  a_pgain_load: assert property (
    @(posedge mclk) disable iff (rst)
    (connect_rise && pgain_optimised <= 16'd12000) |=>
    pgain == $past(pgain_optimised))
    else $error("optimised gain not loaded");
  a_kpv_range: assert property (
    @(posedge mclk) disable iff (rst)
    ($signed(kpvff) >= -2000) && ($signed(kpvff) <= 2000))
    else $error("feedforward out of range");
  a_mt_clear: assert property (
    @(posedge mclk) disable iff (rst)
    mt_reset |=> (turn_count == 16'h0000) && mt_count_clear)
    else $error("revolution count not cleared");
  a_gear_keep: assert property (
    @(posedge mclk) disable iff (rst)
    (wr_gear && !gear_ok) |=> $stable(gear_depth))
    else $error("bad gear write changed value");
  a_pgain_keep: assert property (
    @(posedge mclk) disable iff (rst)
    (wr_pgain && !(pgain_ok && upper_zero) && !connect_rise) |=>
    $stable(pgain))
    else $error("bad gain write changed value");
  a_kpv_keep: assert property (
    @(posedge mclk) disable iff (rst)
    (wr_kpv && !kpv_ok) |=> $stable(kpvff))
    else $error("bad feedforward write changed value");
  a_spd_keep: assert property (
    @(posedge mclk) disable iff (rst)
    (wr_spd && !spd_ok) |=> $stable(spd_src))
    else $error("bad speed source write changed value");

  c_wrap:     cover property (@(posedge mclk) disable iff (rst) wrap_down);
  c_wrap_up:  cover property (@(posedge mclk) disable iff (rst) wrap_up);
  c_reject:   cover property (@(posedge mclk) disable iff (rst)
    wr_kpv && !kpv_ok);
  c_connect:  cover property (@(posedge mclk) disable iff (rst) connect_rise);
  c_defaults: cover property (@(posedge mclk) disable iff (rst) use_defaults);
endmodule : sea_regs
`default_nettype wire
